//--- ddu_chan.sv
// One channel: code formatting and the data latch in front of the converter core
`timescale 1ns/100ps
`include "ddu_consts.svh"
module ddu_chan (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   ddu_chan_if.chan         c,
   output logic [11:0]      o_code
);
   import ddu_pkg::*;

   ddu_chan_state_t st_ff;
   ddu_chan_state_t nxt_st;

   // ----------------------------------------------------------------
   // Code formatting
   // ----------------------------------------------------------------
   // Result is always scaled to the 12-bit core: 8-bit codes sit in the top byte
   function automatic logic [11:0] to_code(input logic [11:0] d, input logic r8,
                                           input logic tc);
      logic [7:0] lo;
      lo = d[7:0];
      if (r8) begin
         if (tc) begin
            lo = lo ^ `DDU_SIGN8;
         end
         return {lo, `DDU_PAD8};
      end
      if (tc) begin
         return (d & `DDU_DAT_MASK12) ^ `DDU_SIGN12;
      end
      return d & `DDU_DAT_MASK12;
   endfunction : to_code

   // ----------------------------------------------------------------
   // Latch
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      if (c.transparent || c.load) begin
         nxt_st.code = to_code(c.data, c.res8, c.twos);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_ff <= '{code: `DDU_CODE_RST};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_code = st_ff.code;

   a_latch_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !c.transparent && !c.load |=> $stable(o_code))
      else $error("Latch changed without a load");
   a_transp_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      c.transparent |=> o_code == to_code($past(c.data), $past(c.res8), $past(c.twos)))
      else $error("Transparent latch does not follow data");

endmodule : ddu_chan

//--- ddu_chan_if.sv
// Carrier from the control logic to one channel's data path
`timescale 1ns/100ps
interface ddu_chan_if;
   logic [11:0] data;
   logic        res8;
   logic        twos;
   logic        transparent;
   logic        load;

   modport ctrl (output data, output res8, output twos, output transparent, output load);
   modport chan (input data, input res8, input twos, input transparent, input load);
endinterface : ddu_chan_if

//--- ddu_consts.svh
// Register indices, reset values, field masks and codes for the dual converter update control
`ifndef DDU_CONSTS_SVH
`define DDU_CONSTS_SVH

// Register indices; byte address is four times the index
`define DDU_IDX_CTL0      10'h1c0
`define DDU_IDX_CTL1      10'h1c2
`define DDU_IDX_DAT0      10'h1c8
`define DDU_IDX_DAT1      10'h1ca
`define DDU_IDX_GIE       10'h1cc

// Reset values
`define DDU_CTL_RST       16'h0000
`define DDU_DAT_RST       12'h000
`define DDU_CODE_RST      12'h000

// Control bits that only change while conversion_enable is clear
`define DDU_CTL_LOCK_MASK 16'hfd10

// Data field masks and sign bits
`define DDU_DAT_MASK12    12'hfff
`define DDU_DAT_MASK8     12'h0ff
`define DDU_SIGN12        12'h800
`define DDU_SIGN8         8'h80
`define DDU_PAD8          4'h0

// Load trigger codes
`define DDU_LSEL_TRANSP   2'h0
`define DDU_LSEL_WRITE    2'h1
`define DDU_LSEL_TMR_A    2'h2
`define DDU_LSEL_TMR_B    2'h3

// Buffer setting that leaves the converter off
`define DDU_AMP_OFF_HIZ   3'h0

// Answer of an unmapped read
`define DDU_RD_NONE       32'h0000_0000

`endif

//--- ddu_far_model.sv
// Far side model: timer compare outputs and the converter core's calibration engine
`timescale 1ns/100ps
module ddu_far_model (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_fire_a,
   input  wire logic       i_fire_b,
   input  wire logic [3:0] i_cal_wait,
   input  wire logic [1:0] i_cal_run,
   output logic            o_timer_a,
   output logic            o_timer_b,
   output logic [1:0]      o_cal_done
);
   logic [3:0] cnt_ff [2];
   // ----
   // Timers follow the bench one cycle late; calibration done pulses i_cal_wait+1 cycles in
   // ----
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_timer_a  <= 1'b0;
         o_timer_b  <= 1'b0;
         o_cal_done <= 2'b00;
         cnt_ff     <= '{4'h0, 4'h0};
      end else begin
         o_timer_a <= i_fire_a;
         o_timer_b <= i_fire_b;
         for (int k = 0; k < 2; k++) begin
            cnt_ff[k]     <= i_cal_run[k] ? cnt_ff[k] + 4'h1 : 4'h0;
            o_cal_done[k] <= i_cal_run[k] && cnt_ff[k] == i_cal_wait;
         end
      end
   end
endmodule : ddu_far_model

//--- ddu_pkg.sv
// Types shared by the dual converter update control
package ddu_pkg;

   // Channel control word, bit 15 down to bit 0
   typedef struct packed {
      logic       out_pin_sel;   // output_pin_select
      logic [1:0] ref_sel;       // reference_select
      logic       res_sel;       // resolution_select, 1 = 8 bit
      logic [1:0] load_sel;      // load_trigger_select
      logic       cal_start;     // calibration_start
      logic       range_sel;     // output_range_select, 1 = 1x
      logic [2:0] buf_set;       // buffer_setting
      logic       fmt_sel;       // data_format_select, 1 = two's complement
      logic       done_ie;       // latch_done_irq_enable
      logic       done_flag;     // latch_done_flag
      logic       conv_en;       // conversion_enable
      logic       grp_next;      // group_with_next
   } ddu_ctl_t;

   typedef enum logic [2:0] {
      DDU_SEL_NONE = 3'b000,
      DDU_SEL_CTL0 = 3'b001,
      DDU_SEL_CTL1 = 3'b010,
      DDU_SEL_DAT0 = 3'b011,
      DDU_SEL_DAT1 = 3'b100,
      DDU_SEL_GIE  = 3'b101
   } ddu_sel_t;

   typedef struct packed {
      ddu_ctl_t [1:0]        ctl;
      logic     [1:0][11:0]  dat;
      logic     [1:0]        pend;
      logic                  prev_ta;
      logic                  prev_tb;
      logic                  global_irq_enable;
      logic                  pready;
      logic     [31:0]       prdata;
      logic                  slverr;
   } ddu_top_state_t;

   typedef struct packed {
      logic [11:0] code;
   } ddu_chan_state_t;

endpackage : ddu_pkg

//--- ddu_update_ctrl.sv
// Update control for two converter channels, grouped when group_with_next is set, with an APB register slave
// Summary of operation
// - 8- or 12-bit mode; 8-bit codes scaled to full 12-bit core range.
// - output_range_select 0 gives three times reference, 1 gives one time.
// - Oversized codes are accepted; bits above the active resolution are ignored.
// - data_format_select picks straight binary or two's complement data.
// - Two's complement: 800h zero, 000h mid-scale, 7FFh full-scale (8-bit alike).
// - Nonzero buffer_setting forces the routed pin to the converter function.
// - output_pin_select routes channels to port 6 bits 6/7 or ext ref/bit 5.
// - reference_select 0,1 picks internal reference; 2,3 external reference input.
// - Three-bit buffer_setting picks one of eight speed/power buffer combinations.
// - Load select 0: latch transparent, updates on write, enable ignored.
// - Load select 1: data latched after a write to the data register.
// - Load select 2/3: latch on timer A compare 1 / timer B compare 2 rise.
// - Nonzero load select latches only while conversion_enable is set.
// - calibration_start runs offset calibration and clears itself when done.
// - group_with_next of channel zero groups both; channel one's bit unused.
// - When grouped, channel one's load select triggers both channels.
// - Grouped: no update until both data registers written since last update.
// - Grouped with both selects nonzero: either enable clear blocks both.
// - Grouped channels update in the same clock cycle.
// - latch_done_flag sets on a latch with nonzero select, never when transparent.
// - Interrupt request when flag, its enable and global enable are set.
// - latch_done_flag stays set until software clears it.
// - Data bits 15 to 12 read as zero and never reach the core.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "ddu_consts.svh"
module ddu_update_ctrl (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_n,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic             o_pready,
   output logic [31:0]      o_prdata,
   output logic             o_pslverr,
   input  wire logic        i_timer_a_cmp1,
   input  wire logic        i_timer_b_cmp2,
   input  wire logic [1:0]  i_cal_done,
   output logic [11:0]      o_ch0_code,
   output logic [11:0]      o_ch1_code,
   output logic [1:0]       o_range_x1,
   output logic [1:0]       o_ref_ext,
   output logic [2:0]       o_ch0_buf_setting,
   output logic [2:0]       o_ch1_buf_setting,
   output logic [1:0]       o_cal_run,
   output logic             o_port6_bit6_dac,
   output logic             o_port6_bit7_dac,
   output logic             o_port6_bit5_dac,
   output logic             o_ext_ref_pin_dac,
   output logic             o_irq
);
   import ddu_pkg::*;

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic [1:0] rst_sync_ff;
   logic       rst_n_sys;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_sync_ff <= 2'b00;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n_sys = rst_sync_ff[1];

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic ddu_sel_t reg_sel(input logic [11:0] a);
      ddu_sel_t s;
      s = DDU_SEL_NONE;
      if (a[1:0] == 2'b00) begin
         unique case (a[11:2])
            `DDU_IDX_CTL0: s = DDU_SEL_CTL0;
            `DDU_IDX_CTL1: s = DDU_SEL_CTL1;
            `DDU_IDX_DAT0: s = DDU_SEL_DAT0;
            `DDU_IDX_DAT1: s = DDU_SEL_DAT1;
            `DDU_IDX_GIE:  s = DDU_SEL_GIE;
            default:       s = DDU_SEL_NONE;
         endcase
      end
      return s;
   endfunction : reg_sel

   // Trigger test for one load select value
   function automatic logic trig_hit(input logic [1:0] ls, input logic wr_pend,
                                     input logic ea, input logic eb);
      logic h;
      h = 1'b0;
      unique case (ls)
         `DDU_LSEL_TRANSP: h = 1'b0;
         `DDU_LSEL_WRITE:  h = wr_pend;
         `DDU_LSEL_TMR_A:  h = ea;
         `DDU_LSEL_TMR_B:  h = eb;
      endcase
      return h;
   endfunction : trig_hit

   ddu_top_state_t st_ff;
   ddu_top_state_t nxt_st;

   ddu_sel_t   sel;
   logic       acc_done;
   logic       wr_en;
   logic       grouped;
   logic       edge_a;
   logic       edge_b;
   logic [1:0] eff_lsel [2];
   logic [1:0] load;
   logic [1:0] transp;
   logic [1:0] ctl_wr;
   logic [1:0] dat_wr;
   logic       grp_go;

   assign sel      = reg_sel(i_paddr);
   assign acc_done = i_psel && i_penable && st_ff.pready;
   assign wr_en    = acc_done && i_pwrite;
   assign ctl_wr   = {wr_en && (sel == DDU_SEL_CTL1), wr_en && (sel == DDU_SEL_CTL0)};
   assign dat_wr   = {wr_en && (sel == DDU_SEL_DAT1), wr_en && (sel == DDU_SEL_DAT0)};

   // ----------------------------------------------------------------
   // Load decision
   // ----------------------------------------------------------------
   assign grouped = st_ff.ctl[0].grp_next;
   assign edge_a  = i_timer_a_cmp1 && !st_ff.prev_ta;
   assign edge_b  = i_timer_b_cmp2 && !st_ff.prev_tb;

   // Both channels waiting, enabled and armed before a grouped update may fire
   assign grp_go = (st_ff.ctl[0].load_sel != `DDU_LSEL_TRANSP)
                && (st_ff.ctl[1].load_sel != `DDU_LSEL_TRANSP)
                && st_ff.ctl[0].conv_en && st_ff.ctl[1].conv_en
                && (&st_ff.pend)
                && trig_hit(st_ff.ctl[1].load_sel, 1'b1, edge_a, edge_b);

   for (genvar g = 0; g < 2; g++) begin : g_load
      assign eff_lsel[g] = grouped ? st_ff.ctl[1].load_sel
                                   : st_ff.ctl[g].load_sel;
      assign transp[g]   = (eff_lsel[g] == `DDU_LSEL_TRANSP);
      assign load[g]     = grouped ? grp_go
                         : (!transp[g] && st_ff.ctl[g].conv_en
                            && trig_hit(eff_lsel[g], st_ff.pend[g],
                                        edge_a, edge_b));
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st         = st_ff;
      nxt_st.prev_ta = i_timer_a_cmp1;
      nxt_st.prev_tb = i_timer_b_cmp2;
      nxt_st.pready  = i_psel && i_penable && !st_ff.pready;

      for (int ch = 0; ch < 2; ch++) begin
         // Control write: locked fields keep their value while enabled
         if (ctl_wr[ch]) begin
            if (st_ff.ctl[ch].conv_en) begin
               nxt_st.ctl[ch] = (i_pwdata[15:0] & ~`DDU_CTL_LOCK_MASK)
                              | (st_ff.ctl[ch] & `DDU_CTL_LOCK_MASK);
            end else begin
               nxt_st.ctl[ch] = i_pwdata[15:0];
            end
         end
         // Calibration ends on the core's done pulse unless restarted now
         if (st_ff.ctl[ch].cal_start && i_cal_done[ch] && !ctl_wr[ch]) begin
            nxt_st.ctl[ch].cal_start = 1'b0;
         end
         // Pending write marker; a new write wins over the clear of a load
         if (load[ch]) begin
            nxt_st.pend[ch] = 1'b0;
         end
         if (dat_wr[ch]) begin
            nxt_st.dat[ch]  = i_pwdata[11:0];
            nxt_st.pend[ch] = 1'b1;
         end
         // Latch-done flag: hardware set wins over a software clear
         if (load[ch]) begin
            nxt_st.ctl[ch].done_flag = 1'b1;
         end
      end

      if (wr_en && (sel == DDU_SEL_GIE)) begin
         nxt_st.global_irq_enable = i_pwdata[0];
      end

      // Read data and error answer, captured in the first access cycle
      if (i_psel && i_penable && !st_ff.pready) begin
         nxt_st.slverr = (sel == DDU_SEL_NONE);
         unique case (sel)
            DDU_SEL_CTL0: nxt_st.prdata = {16'h0000, st_ff.ctl[0]};
            DDU_SEL_CTL1: nxt_st.prdata = {16'h0000, st_ff.ctl[1]};
            DDU_SEL_DAT0: nxt_st.prdata = {20'h00000, st_ff.dat[0]};
            DDU_SEL_DAT1: nxt_st.prdata = {20'h00000, st_ff.dat[1]};
            DDU_SEL_GIE:  nxt_st.prdata = {31'h00000000, st_ff.global_irq_enable};
            DDU_SEL_NONE: nxt_st.prdata = `DDU_RD_NONE;
            default:      nxt_st.prdata = `DDU_RD_NONE;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge rst_n_sys) begin
      if (!rst_n_sys) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // Channel data paths
   // ----------------------------------------------------------------
   ddu_chan_if chan_bus [2] ();
   logic [11:0] code [2];

   for (genvar g = 0; g < 2; g++) begin : g_chan
      assign chan_bus[g].data        = st_ff.dat[g];
      assign chan_bus[g].res8        = st_ff.ctl[g].res_sel;
      assign chan_bus[g].twos        = st_ff.ctl[g].fmt_sel;
      assign chan_bus[g].transparent = transp[g];
      assign chan_bus[g].load        = load[g];

      ddu_chan u_chan (
         .i_clk   (i_clk_sys),
         .i_rst_n (rst_n_sys),
         .c       (chan_bus[g]),
         .o_code  (code[g])
      );

      assign o_range_x1[g] = st_ff.ctl[g].range_sel;
      assign o_ref_ext[g]  = st_ff.ctl[g].ref_sel[1];
      assign o_cal_run[g]  = st_ff.ctl[g].cal_start;
   end

   assign o_ch0_code        = code[0];
   assign o_ch1_code        = code[1];
   assign o_ch0_buf_setting = st_ff.ctl[0].buf_set;
   assign o_ch1_buf_setting = st_ff.ctl[1].buf_set;

   // ----------------------------------------------------------------
   // Pin routing overrides
   // ----------------------------------------------------------------
   logic ch0_on;
   logic ch1_on;
   assign ch0_on = st_ff.ctl[0].buf_set != `DDU_AMP_OFF_HIZ;
   assign ch1_on = st_ff.ctl[1].buf_set != `DDU_AMP_OFF_HIZ;

   assign o_port6_bit6_dac  = ch0_on && !st_ff.ctl[0].out_pin_sel;
   assign o_ext_ref_pin_dac = ch0_on &&  st_ff.ctl[0].out_pin_sel;
   assign o_port6_bit7_dac  = ch1_on && !st_ff.ctl[1].out_pin_sel;
   assign o_port6_bit5_dac  = ch1_on &&  st_ff.ctl[1].out_pin_sel;

   // ----------------------------------------------------------------
   // Interrupt and bus outputs
   // ----------------------------------------------------------------
   assign o_irq = st_ff.global_irq_enable && ((st_ff.ctl[0].done_flag && st_ff.ctl[0].done_ie)
                             || (st_ff.ctl[1].done_flag && st_ff.ctl[1].done_ie));

   assign o_pready  = st_ff.pready;
   assign o_prdata  = st_ff.prdata;
   assign o_pslverr = st_ff.slverr && st_ff.pready;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!rst_n_sys);

   sequence s_dat0_write_armed;
      dat_wr[0] && !grouped && st_ff.ctl[0].conv_en && !ctl_wr[0]
      && (st_ff.ctl[0].load_sel == `DDU_LSEL_WRITE);
   endsequence

   sequence s_cal_end0;
      st_ff.ctl[0].cal_start && i_cal_done[0] && !ctl_wr[0];
   endsequence

   a_write_then_load: assert property (s_dat0_write_armed |=> load[0])
      else $error("Write-triggered load did not follow data write");
   a_load_sets_flag: assert property (load[0] |=> st_ff.ctl[0].done_flag)
      else $error("Latch did not set done flag");
   a_flag_sticky: assert property (
      st_ff.ctl[0].done_flag && !ctl_wr[0] |=> st_ff.ctl[0].done_flag)
      else $error("Done flag dropped without software clear");
   a_transp_no_flag: assert property (
      transp[1] && !st_ff.ctl[1].done_flag && !ctl_wr[1] |=> !st_ff.ctl[1].done_flag)
      else $error("Done flag set in transparent mode");
   a_group_same_cycle: assert property (grouped |-> load[0] == load[1])
      else $error("Grouped channels loaded in different cycles");
   a_group_wait_both: assert property (grouped && !(&st_ff.pend) |-> !load[0])
      else $error("Grouped update before both data writes");
   a_group_enable: assert property (
      grouped && !(st_ff.ctl[0].conv_en && st_ff.ctl[1].conv_en) |-> load == 2'b00)
      else $error("Grouped update with an enable clear");
   a_enc_blocks: assert property (
      !grouped && !st_ff.ctl[1].conv_en |-> !load[1])
      else $error("Load while conversion disabled");
   a_cal_self_clear: assert property (s_cal_end0 |=> !o_cal_run[0])
      else $error("Calibration bit not cleared on completion");
   a_irq_cause: assert property (
      $rose(o_irq) |-> st_ff.global_irq_enable && (st_ff.ctl[0].done_ie || st_ff.ctl[1].done_ie))
      else $error("Interrupt without enables");
   a_pin_forced: assert property (
      ch1_on |-> o_port6_bit7_dac != o_port6_bit5_dac)
      else $error("Channel one pin not forced");
   a_apb_answer: assert property (i_psel && i_penable && !o_pready |=> o_pready)
      else $error("APB access not answered in time");

   sequence s_tmr_a_rise0;
      !grouped && st_ff.ctl[0].conv_en && edge_a
      && (st_ff.ctl[0].load_sel == `DDU_LSEL_TMR_A);
   endsequence

   sequence s_tmr_b_rise0;
      !grouped && st_ff.ctl[0].conv_en && edge_b
      && (st_ff.ctl[0].load_sel == `DDU_LSEL_TMR_B);
   endsequence

   a_timer_a_load: assert property (s_tmr_a_rise0 |-> load[0])
      else $error("Timer A rise did not load channel zero");
   a_timer_b_load: assert property (s_tmr_b_rise0 |-> load[0])
      else $error("Timer B rise did not load channel zero");
   a_timer_edge_only: assert property (
      !grouped && (st_ff.ctl[0].load_sel == `DDU_LSEL_TMR_A) && !edge_a |-> !load[0])
      else $error("Timer load without a rising edge");
   a_group_fire: assert property (
      grouped && (&st_ff.pend) && st_ff.ctl[0].conv_en && st_ff.ctl[1].conv_en
      && (st_ff.ctl[0].load_sel != `DDU_LSEL_TRANSP)
      && (st_ff.ctl[1].load_sel == `DDU_LSEL_WRITE) |-> load == 2'b11)
      else $error("Grouped update missed its trigger");
   a_pend_on_write: assert property (dat_wr[1] |=> st_ff.pend[1])
      else $error("Data write not marked pending");
   a_irq_raise: assert property (
      st_ff.global_irq_enable && st_ff.ctl[0].done_flag && st_ff.ctl[0].done_ie |-> o_irq)
      else $error("Interrupt not raised");
   a_pin_off: assert property (
      !ch0_on |-> !o_port6_bit6_dac && !o_ext_ref_pin_dac)
      else $error("Channel zero pin forced while off");
   a_apb_error: assert property (
      i_psel && i_penable && !o_pready && (sel == DDU_SEL_NONE) |=> o_pslverr)
      else $error("Unmapped access without error answer");

endmodule : ddu_update_ctrl

//--- testbench.sv
// Self-checking bench for the dual converter update control
`timescale 1ns/100ps
`include "ddu_consts.svh"
module testbench;
   import ddu_pkg::*;
   localparam logic [11:0] a_c0 = {`DDU_IDX_CTL0, 2'b00};
   localparam logic [11:0] a_c1 = {`DDU_IDX_CTL1, 2'b00};
   localparam logic [11:0] a_d0 = {`DDU_IDX_DAT0, 2'b00};
   localparam logic [11:0] a_d1 = {`DDU_IDX_DAT1, 2'b00};
   localparam logic [11:0] a_gi = {`DDU_IDX_GIE, 2'b00};
   logic        clk, rst_n, psel, penable, pwrite, pready, perr, err, irq;
   logic        fire_a, fire_b, tmr_a, tmr_b, p66, pref, p67, p65;
   logic [11:0] paddr, code0, code1, e0, e1;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] c, v, corner [4];
   logic [3:0]  cwait;
   logic [2:0]  buf0, buf1;
   logic [1:0]  rx1, rext, crun, cdone;
   int          num_errors, tests_run, cycles;

   ddu_update_ctrl dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
      .o_prdata(prdata), .o_pslverr(perr), .i_timer_a_cmp1(tmr_a), .i_timer_b_cmp2(tmr_b),
      .i_cal_done(cdone), .o_ch0_code(code0), .o_ch1_code(code1), .o_range_x1(rx1),
      .o_ref_ext(rext), .o_ch0_buf_setting(buf0), .o_ch1_buf_setting(buf1), .o_cal_run(crun),
      .o_port6_bit6_dac(p66), .o_port6_bit7_dac(p67), .o_port6_bit5_dac(p65),
      .o_ext_ref_pin_dac(pref), .o_irq(irq));
   ddu_far_model far_u (.i_clk(clk), .i_rst_n(rst_n), .i_fire_a(fire_a), .i_fire_b(fire_b),
      .i_cal_wait(cwait), .i_cal_run(crun), .o_timer_a(tmr_a), .o_timer_b(tmr_b),
      .o_cal_done(cdone));

   // ----
   // Tasks
   // ----
   task close_out;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out

   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = perr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task pulse(input logic sel_a);
      @(posedge clk);
      fire_a <= sel_a;
      fire_b <= !sel_a;
      @(posedge clk);
      fire_a <= 1'b0;
      fire_b <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : pulse

   function automatic logic [11:0] exp_code(input logic [15:0] k, input logic [11:0] d);
      if (k[12]) return {d[7] ^ k[4], d[6:0], `DDU_PAD8};
      return {d[11] ^ k[4], d[10:0]};
   endfunction : exp_code

   // ----
   // Clock, timeout and main sequence
   // ----
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         num_errors++;
         close_out();
      end
   end

   initial begin
      {rst_n, psel, penable, pwrite, fire_a, fire_b, paddr, pwdata, cwait} = '0;
      corner = '{16'h0800, 16'h0000, 16'h07ff, 16'hff80};
      e1 = 12'h000;
      c = 16'($urandom(30102));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      apb(1'b0, a_c0, 0);
      chk("ctl0", rd, `DDU_CTL_RST);
      chk("code0", code0, `DDU_CODE_RST);
      apb(1'b1, 12'h704, 32'hffff);
      chk("slverr", err, 1);
      for (int i = 0; i < 12; i++) begin
         v = (i < 4) ? corner[i] : 16'($urandom);
         c = {1'($urandom), 2'($urandom), i[0], 4'h0, 3'($urandom), (i < 4) | i[1], 4'h0};
         c[8] = 1'($urandom);
         apb(1'b1, a_c0, {16'h0, c});
         apb(1'b1, a_c1, {16'h0, c});
         apb(1'b1, a_d0, {16'h0, v});
         repeat (3) @(posedge clk);
         chk("code0", code0, exp_code(c, v[11:0]));
         chk("range", rx1, {2{c[8]}});
         chk("ref", rext, {2{c[14]}});
         chk("buf0", buf0, c[7:5]);
         chk("buf1", buf1, c[7:5]);
         chk("p66", p66, c[7:5] != 0 && !c[15]);
         chk("pref", pref, c[7:5] != 0 && c[15]);
         chk("p67", p67, c[7:5] != 0 && !c[15]);
         chk("p65", p65, c[7:5] != 0 && c[15]);
         apb(1'b0, a_d0, 0);
         chk("dat0", rd, {20'h0, v[11:0]});
      end
      apb(1'b0, a_c0, 0);
      chk("ctl0", rd, {16'h0, c});
      apb(1'b1, a_c0, 32'h040a);
      apb(1'b1, a_gi, 32'h1);
      v = 16'($urandom);
      apb(1'b1, a_d0, {16'h0, v});
      e0 = v[11:0];
      repeat (8) @(posedge clk);
      chk("code0", code0, e0);
      chk("irq", irq, 1);
      apb(1'b1, a_gi, 0);
      @(posedge clk);
      chk("irq", irq, 0);
      apb(1'b1, a_c0, 32'h0408);
      apb(1'b1, a_gi, 32'h1);
      apb(1'b1, a_d0, $urandom);
      repeat (3) @(posedge clk);
      chk("irq", irq, 0);
      chk("code0", code0, e0);
      for (int m = 2; m < 4; m++) begin
         apb(1'b1, a_c0, {20'h0, m[1:0], 10'h0});
         apb(1'b1, a_c0, {20'h0, m[1:0], 10'h2});
         v = 16'($urandom);
         apb(1'b1, a_d0, {16'h0, v});
         pulse(m == 3);
         chk("code0", code0, e0);
         pulse(m == 2);
         e0 = v[11:0];
         chk("code0", code0, e0);
      end
      apb(1'b1, a_c0, 32'h0);
      apb(1'b1, a_c0, 32'h0803);
      apb(1'b1, a_c1, 32'h0402);
      for (int k = 0; k < 2; k++) begin
         v = 16'($urandom);
         c = 16'($urandom);
         apb(1'b1, a_d0, {16'h0, v});
         repeat (3) @(posedge clk);
         chk("code0", code0, e0);
         apb(1'b1, a_d1, {16'h0, c});
         repeat (3) @(posedge clk);
         if (k == 0) {e0, e1} = {v[11:0], c[11:0]};
         chk("code0", code0, e0);
         chk("code1", code1, e1);
         apb(1'b1, a_c1, 32'h0400);
      end
      cwait <= 4'($urandom);
      apb(1'b1, a_c0, 32'h0);
      apb(1'b1, a_c0, 32'h0040);
      apb(1'b1, a_c0, 32'h0240);
      @(posedge clk);
      chk("cal run", crun, 2'b01);
      for (int n = 0; n < 40 && crun[0] === 1'b1; n++) @(posedge clk);
      apb(1'b0, a_c0, 0);
      chk("ctl0", rd, 32'h0040);
      close_out();
   end
endmodule : testbench
